// *** hw/table_move_consts.vh ***
`ifndef TABLE_MOVE_CONSTS_VH
`define TABLE_MOVE_CONSTS_VH
`define PTR_ZERO      16'h0000
`define PTR_STEP      16'h0001
`define PTR_WRAP      16'h0001
`define DATA_OFFSET   16'h0001
`define WORD_RESET    16'h0000
`define ST_IDLE       3'h0
`define ST_PTR_ISSUE  3'h1
`define ST_PTR_EVAL   3'h2
`define ST_DAT_ISSUE  3'h3
`define ST_DAT_CAP    3'h4
`define ST_DAT_WRITE  3'h5
`define ST_PTR_WRITE  3'h6
`endif

// *** hw/table_pointer_move_unit.v ***
`timescale 1ns/1ps
`include "table_move_consts.vh"

module table_pointer_move_unit #(
  parameter AW = 16,
  parameter DW = 16,
  parameter LW = 8
) (
  input  wire          mclk_in,
  input  wire          rst_in,
  input  wire          scan_start_in,
  input  wire          scan_end_in,
  input  wire          enable_in,
  input  wire          remove_from_bottom_op_in,
  input  wire [LW-1:0] table_length_in,
  input  wire [AW-1:0] table_start_in,
  input  wire [AW-1:0] operand_addr_in,
  input  wire          flag_reuse_in,
  input  wire [DW-1:0] mem_rdata_in,
  output reg  [AW-1:0] mem_addr_out,
  output reg           mem_rd_out,
  output reg           mem_wr_out,
  output reg  [DW-1:0] mem_wdata_out,
  output reg           busy_out,
  output reg           done_out,
  output reg           moved_out,
  output reg           table_status_flag_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Word address of a table entry relative to the pointer word.
  function [AW-1:0] entry_addr;
    input [AW-1:0] base;
    input [DW-1:0] index;
    begin
      entry_addr = base + index[AW-1:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  reg [2:0]    state_q;
  reg          rfb_q;
  reg [DW-1:0] len_q;
  reg [AW-1:0] start_q;
  reg [AW-1:0] operand_q;
  reg [DW-1:0] ptr_new_q;
  reg [AW-1:0] target_q;
  reg          flag_set_q;

  wire [DW-1:0] len_ext;
  assign len_ext = {{(DW-LW){1'b0}}, table_length_in};

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk_in) begin
    if (rst_in) begin
      state_q               <= `ST_IDLE;
      rfb_q                 <= 1'b0;
      len_q                 <= `WORD_RESET;
      start_q               <= {AW{1'b0}};
      operand_q             <= {AW{1'b0}};
      ptr_new_q             <= `WORD_RESET;
      target_q              <= {AW{1'b0}};
      flag_set_q            <= 1'b0;
      mem_addr_out          <= {AW{1'b0}};
      mem_rd_out            <= 1'b0;
      mem_wr_out            <= 1'b0;
      mem_wdata_out         <= `WORD_RESET;
      busy_out              <= 1'b0;
      done_out              <= 1'b0;
      moved_out             <= 1'b0;
      table_status_flag_out <= 1'b0;
    end else begin
      mem_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      done_out   <= 1'b0;
      // The flag set at completion wins over any clear in that cycle.
      if (done_out && flag_set_q) begin
        table_status_flag_out <= 1'b1;
      end else if (scan_end_in || flag_reuse_in) begin
        table_status_flag_out <= 1'b0;
      end
      case (state_q)
        `ST_IDLE: begin
          if (scan_start_in && enable_in) begin
            rfb_q        <= remove_from_bottom_op_in;
            len_q        <= len_ext;
            start_q      <= table_start_in;
            operand_q    <= operand_addr_in;
            mem_addr_out <= table_start_in;
            mem_rd_out   <= 1'b1;
            busy_out     <= 1'b1;
            moved_out    <= 1'b0;
            state_q      <= `ST_PTR_ISSUE;
          end
        end
        `ST_PTR_ISSUE: begin
          state_q <= `ST_PTR_EVAL;
        end
        `ST_PTR_EVAL: begin
          if (rfb_q) begin
            if (mem_rdata_in == `PTR_ZERO) begin
              flag_set_q <= 1'b1;
              done_out   <= 1'b1;
              busy_out   <= 1'b0;
              state_q    <= `ST_IDLE;
            end else begin
              ptr_new_q    <= mem_rdata_in - `PTR_STEP;
              flag_set_q   <= (mem_rdata_in == `PTR_STEP);
              mem_addr_out <= entry_addr(start_q, mem_rdata_in);
              target_q     <= operand_q;
              mem_rd_out   <= 1'b1;
              state_q      <= `ST_DAT_ISSUE;
            end
          end else begin
            if (mem_rdata_in > len_q) begin
              flag_set_q <= 1'b0;
              done_out   <= 1'b1;
              busy_out   <= 1'b0;
              state_q    <= `ST_IDLE;
            end else begin
              if (mem_rdata_in == len_q) begin
                ptr_new_q <= `PTR_WRAP;
                target_q  <= entry_addr(start_q, `DATA_OFFSET);
                flag_set_q <= (len_q == `PTR_WRAP);
              end else begin
                ptr_new_q <= mem_rdata_in + `PTR_STEP;
                target_q  <= entry_addr(start_q,
                                        mem_rdata_in + `PTR_STEP);
                flag_set_q <= ((mem_rdata_in + `PTR_STEP) == len_q);
              end
              mem_addr_out <= operand_q;
              mem_rd_out   <= 1'b1;
              state_q      <= `ST_DAT_ISSUE;
            end
          end
        end
        `ST_DAT_ISSUE: begin
          state_q <= `ST_DAT_CAP;
        end
        `ST_DAT_CAP: begin
          mem_addr_out  <= target_q;
          mem_wdata_out <= mem_rdata_in;
          mem_wr_out    <= 1'b1;
          state_q       <= `ST_DAT_WRITE;
        end
        `ST_DAT_WRITE: begin
          mem_addr_out  <= start_q;
          mem_wdata_out <= ptr_new_q;
          mem_wr_out    <= 1'b1;
          state_q       <= `ST_PTR_WRITE;
        end
        `ST_PTR_WRITE: begin
          done_out  <= 1'b1;
          moved_out <= 1'b1;
          busy_out  <= 1'b0;
          state_q   <= `ST_IDLE;
        end
        default: begin
          busy_out <= 1'b0;
          state_q  <= `ST_IDLE;
        end
      endcase
    end
  end

endmodule // table_pointer_move_unit

// *** test/table_move_properties.sv ***
`timescale 1ns/1ps
module table_move_properties (
  input wire        mclk_in,
  input wire        rst_in,
  input wire        scan_start_in,
  input wire        scan_end_in,
  input wire        enable_in,
  input wire        flag_reuse_in,
  input wire [15:0] table_start_in,
  input wire [15:0] mem_addr_out,
  input wire        mem_rd_out,
  input wire        mem_wr_out,
  input wire        busy_out,
  input wire        done_out,
  input wire        moved_out,
  input wire        table_status_flag_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  accept_rd_a: assert property (scan_start_in && enable_in
    && !busy_out && !done_out |=> mem_rd_out && busy_out
    && mem_addr_out == $past(table_start_in)) else $error("no ptr read");
  done_time_a: assert property ($rose(busy_out) |->
    (##2 (done_out && !moved_out)) or (##6 (done_out && moved_out)))
    else $error("done late");
  wr_pair_a: assert property ($rose(mem_wr_out) |=>
    mem_wr_out ##1 done_out) else $error("write pair bad");
  done_one_a: assert property (done_out |=> !done_out)
    else $error("done long");
  no_start_a: assert property (!(scan_start_in && enable_in)
    && !busy_out && !done_out |=> !busy_out) else $error("stray run");
  idle_quiet_a: assert property (!busy_out |->
    !mem_rd_out && !mem_wr_out) else $error("idle access");
  flag_clr_a: assert property ((scan_end_in || flag_reuse_in)
    && !done_out |=> !table_status_flag_out) else $error("flag kept");
  flag_rise_a: assert property ($rose(table_status_flag_out)
    |-> $past(done_out)) else $error("flag early");
  cover property (done_out && moved_out);
  cover property (done_out && !moved_out);
  cover property ($rose(table_status_flag_out));
endmodule // table_move_properties

// *** test/word_memory_model.sv ***
`timescale 1ns/1ps
module word_memory_model (
  input  wire        mclk_in,
  input  wire [15:0] addr_in,
  input  wire        rd_in,
  input  wire        wr_in,
  input  wire [15:0] wdata_in,
  output reg  [15:0] rdata_out = 16'h0000
);
  reg [15:0] mem [0:255];
  // Read data lasts one cycle, then the bus shows junk.
  always @(posedge mclk_in) begin
    rdata_out <= rd_in ? mem[addr_in[7:0]] : ~rdata_out;
    if (wr_in) begin
      mem[addr_in[7:0]] <= wdata_in;
    end
  end
endmodule // word_memory_model

// *** test/table_pointer_move_unit_test.sv ***
`timescale 1ns/1ps
module table_pointer_move_unit_test;
  logic        mclk_in = 1'b0;
  logic        rst_in, scan_start_in, scan_end_in, enable_in;
  logic        remove_from_bottom_op_in, flag_reuse_in;
  logic [7:0]  table_length_in;
  logic [15:0] table_start_in, operand_addr_in, mem_rdata_in;
  logic [15:0] mem_addr_out, mem_wdata_out;
  logic        mem_rd_out, mem_wr_out, busy_out, done_out, moved_out;
  logic        table_status_flag_out;
  int          err_count = 0;
  int          checked = 0;
  always #25 mclk_in = ~mclk_in;
  table_pointer_move_unit dut_u (.*);
  word_memory_model mem_u (.mclk_in, .addr_in(mem_addr_out),
    .rd_in(mem_rd_out), .wr_in(mem_wr_out), .wdata_in(mem_wdata_out),
    .rdata_out(mem_rdata_in));
  task summarize;
    if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task cmp(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: %h vs %h", $time, g, e);
    end
  endtask
  task run(input logic r, input logic [15:0] a, p, input logic m, f, u);
    int n;
    remove_from_bottom_op_in = r;
    operand_addr_in = a;
    scan_start_in = 1'b1;
    @(negedge mclk_in);
    scan_start_in = 1'b0;
    for (n = 0; done_out !== 1'b1; n++) begin
      if (n > 9) begin
        err_count++;
        summarize;
      end
      @(negedge mclk_in);
    end
    cmp(moved_out, m);
    @(negedge mclk_in);
    cmp(table_status_flag_out, f);
    cmp(mem_u.mem[table_start_in[7:0]], p);
    {flag_reuse_in, scan_end_in} = {u, !u};
    @(negedge mclk_in);
    {flag_reuse_in, scan_end_in} = 2'h0;
    @(negedge mclk_in);
    cmp(table_status_flag_out, 1'b0);
  endtask
  task store_wrap;
    table_length_in = 8'h03;
    table_start_in = 16'h0010;
    mem_u.mem[8'h10] = 16'h0000;
    mem_u.mem[8'h40] = 16'hA1A1;
    run(1'b0, 16'h0040, 16'h0001, 1'b1, 1'b0, 1'b0);
    cmp(mem_u.mem[8'h11], 16'hA1A1);
    mem_u.mem[8'h40] = 16'hB2B2;
    run(1'b0, 16'h0040, 16'h0002, 1'b1, 1'b0, 1'b0);
    cmp(mem_u.mem[8'h12], 16'hB2B2);
    run(1'b0, 16'h0040, 16'h0003, 1'b1, 1'b1, 1'b0);
    mem_u.mem[8'h40] = 16'hC3C3;
    run(1'b0, 16'h0040, 16'h0001, 1'b1, 1'b0, 1'b0);
    cmp(mem_u.mem[8'h11], 16'hC3C3);
    mem_u.mem[8'h10] = 16'h0005;
    run(1'b0, 16'h0040, 16'h0005, 1'b0, 1'b0, 1'b0);
    cmp(mem_u.mem[8'h11], 16'hC3C3);
  endtask
  task remove_down;
    table_start_in = 16'h0020;
    mem_u.mem[8'h20] = 16'h0002;
    mem_u.mem[8'h21] = 16'h1111;
    mem_u.mem[8'h22] = 16'h2222;
    run(1'b1, 16'h0050, 16'h0001, 1'b1, 1'b0, 1'b0);
    cmp(mem_u.mem[8'h50], 16'h2222);
    run(1'b1, 16'h0050, 16'h0000, 1'b1, 1'b1, 1'b0);
    cmp(mem_u.mem[8'h50], 16'h1111);
    mem_u.mem[8'h50] = 16'h5A5A;
    run(1'b1, 16'h0050, 16'h0000, 1'b0, 1'b1, 1'b1);
    cmp(mem_u.mem[8'h50], 16'h5A5A);
  endtask
  task gate_off;
    enable_in = 1'b0;
    scan_start_in = 1'b1;
    @(negedge mclk_in);
    scan_start_in = 1'b0;
    enable_in = 1'b1;
    cmp(busy_out, 1'b0);
  endtask
  initial begin
    {rst_in, scan_start_in, scan_end_in, enable_in} = 4'h8;
    {remove_from_bottom_op_in, flag_reuse_in} = 2'h0;
    {table_length_in, table_start_in, operand_addr_in} = 40'h0;
    repeat (2) @(negedge mclk_in);
    rst_in = 1'b0;
    enable_in = 1'b1;
    store_wrap;
    remove_down;
    gate_off;
    summarize;
  end
endmodule // table_pointer_move_unit_test
bind table_pointer_move_unit table_move_properties chk_u (.*);
